// ==== verilog/uart_rx_regs.svh ====
`ifndef URX_UART_RX_REGS_SVH
`define URX_UART_RX_REGS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define URX_OFF_CTRL     8'h00
`define URX_OFF_BAUD     8'h04
`define URX_OFF_STATUS   8'h08
`define URX_OFF_DATA     8'h0c

// ****************************************
// reset values
// ****************************************
`define URX_CTRL_RST     11'h000
`define URX_BAUD_RST     16'h0001
`define URX_STAT_RST     5'h00

// ****************************************
// oversampling and frame timing
// ****************************************
`define URX_OVS          5'h10
`define URX_PH_FIRST     5'h01
`define URX_PH_RT2       5'h02
`define URX_PH_RT3       5'h03
`define URX_PH_RT4       5'h04
`define URX_PH_RT5       5'h05
`define URX_PH_RT7       5'h07
`define URX_PH_RT8       5'h08
`define URX_PH_RT9       5'h09
`define URX_PH_RT10      5'h0a
`define URX_PH_RT11      5'h0b
`define URX_STOP_BEG_8   8'h97
`define URX_STOP_BEG_9   8'ha7
`define URX_STOP_END_8   8'h9a
`define URX_STOP_END_9   8'haa
`define URX_BITS_8       4'h8
`define URX_BITS_9       4'h9
`define URX_IDLE_8       8'ha0
`define URX_IDLE_9       8'hb0

`endif

// ==== verilog/urx_pkg.sv ====
package urx_pkg;

  typedef struct packed {
    logic standby_request;
    logic transmit_polarity;
    logic receive_polarity;
    logic shared_pin_direction;
    logic receive_source_select;
    logic loop_enable;
    logic idle_count_origin;
    logic wake_select;
    logic char_len_nine;
    logic transmitter_enable;
    logic receiver_enable;
  } urx_ctrl_t;

  typedef struct packed {
    logic overrun;
    logic framing_err;
    logic noise_err;
    logic idle_flag;
    logic rx_buffer_full_flag;
  } urx_stat_t;

  typedef enum logic [1:0] {
    URX_S_IDLE,
    URX_S_START,
    URX_S_DATA,
    URX_S_STOP
  } urx_state_t;

endpackage

// ==== verilog/urx_rx.sv ====
`timescale 1ns/10ps
`include "uart_rx_regs.svh"

// What this block does
// (R01) sampling clock runs at sixteen times baud; its phases time every sample
// (R02) eight or nine data bits, chosen by the length control bit
// (R03) stop samples at phases 8, 9, 10 not all equal: noise error
// (R04) majority of stop samples zero: framing error
// (R05) realign oversampling phase on valid falling edges inside the frame
// (R06) eight-bit frames: stop sampling starts 151 cycles after start edge
// (R07) nine-bit frames: stop sampling starts 167 cycles after start edge
// (R08) stop sampling ends at 154 (eight-bit) or 170 (nine-bit) cycles
// (R09) standby request set by software suppresses all receiver requests
// (R10) in standby data still reaches the buffer, buffer-full flag stays clear
// (R11) wake select zero picks idle-line wakeup, one picks address-mark
// (R12) idle-line wakeup: idle on the line clears the standby request
// (R13) the waking idle sets neither idle flag nor buffer-full flag
// (R14) idle counting starts after start bit or after stop bit, by origin bit
// (R15) idle is ten ones in eight-bit mode, eleven in nine-bit mode
// (R16) address-mark wakeup: most significant data bit one clears standby
// (R17) address frame clears standby before stop and sets buffer-full flag
// (R18) idle-line wakeup may leave standby at once if the line was idle
// (R19) loop plus source select: receive pin isolated, transmit pin feeds receiver
// (R20) software enables transmitter and receiver before single-wire or loop use
// (R21) single-wire: pin direction zero means input, one means driven output
// (R22) single-wire: receive polarity set inverts data from the transmit pin
// (R23) loop without source select: transmitter output feeds receiver directly
// (R24) looped stream passes the receive polarity, so polarities must match
// (R25) single-wire input direction: shared pin left undriven
module urx_rx #(
  parameter int ADDR_W = 8,
  parameter int DIV_W  = 16
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // serial pins
  input  wire logic              rxd_pin,
  input  wire logic              txd_pin_in,
  output logic                   txd_pin_out,
  output logic                   txd_pin_oe,
  // local transmitter stream and request
  input  wire logic              tx_serial,
  output logic                   rx_request
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (ADDR_W < 8) begin : g_chk_addr
    $error("ADDR_W too small for the register map");
  end
  if (DIV_W < 1 || DIV_W > 16) begin : g_chk_div
    $error("DIV_W must be 1..16");
  end

  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic mixed3(input logic [2:0] v);
    mixed3 = (v != 3'h0) && (v != 3'h7);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[7:0] == `URX_OFF_CTRL) || (a[7:0] == `URX_OFF_BAUD) ||
             (a[7:0] == `URX_OFF_STATUS) || (a[7:0] == `URX_OFF_DATA);
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] rxd_sync_r;
  logic [1:0] txd_sync_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_sync_r <= 2'h3;
      txd_sync_r <= 2'h3;
    end else begin
      rxd_sync_r <= {rxd_sync_r[0], rxd_pin};
      txd_sync_r <= {txd_sync_r[0], txd_pin_in};
    end
  end

  // ****************************************
  // register state
  // ****************************************
  urx_pkg::urx_ctrl_t ctrl_r,  ctrl_nxt;
  urx_pkg::urx_stat_t stat_r,  stat_nxt;
  logic [DIV_W-1:0]   div_r,   div_nxt;
  logic [8:0]         data_r,  data_nxt;
  logic               idle_arm_r, idle_arm_nxt;
  logic [31:0]        prdata_nxt;
  logic               pready_nxt, pslverr_nxt, txd_out_nxt, txd_oe_nxt, req_nxt;

  // receiver events, combinational, consumed by the register group
  logic               frame_done, wake_idle, wake_addr, idle_evt;
  logic [8:0]         frame_data;
  logic [2:0]         stop_smp;
  logic               data_noise;

  // ****************************************
  // receive source selection
  // ****************************************
  logic rx_src;
  logic rx_bit;

  always_comb begin
    if (ctrl_r.loop_enable && ctrl_r.receive_source_select) begin
      rx_src = txd_sync_r[1];                                // R19
    end else if (ctrl_r.loop_enable) begin
      rx_src = tx_serial;                                    // R23
    end else begin
      rx_src = rxd_sync_r[1];
    end
    // polarity also applies to the looped stream
    rx_bit = rx_src ^ ctrl_r.receive_polarity;               // R22 R24
  end

  // ****************************************
  // oversampling tick
  // ****************************************
  logic [DIV_W-1:0] bcnt_r, bcnt_nxt;
  logic             rt_tick;

  always_comb begin
    rt_tick  = (bcnt_r == '0);
    bcnt_nxt = rt_tick ? ((div_r > 1) ? div_r - 1'b1 : '0) : bcnt_r - 1'b1;   // R01
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_r <= '0;
    end else begin
      bcnt_r <= bcnt_nxt;
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  urx_pkg::urx_state_t st_r, st_nxt;
  logic [4:0] ph_r,   ph_nxt;
  logic [3:0] idx_r,  idx_nxt;
  logic [7:0] frm_r,  frm_nxt;
  logic [2:0] hist_r, hist_nxt;
  logic [2:0] smp_r,  smp_nxt;
  logic [8:0] sh_r,   sh_nxt;
  logic       last_r, last_nxt;
  logic       nz_r,   nz_nxt;
  logic       rs_r,   rs_nxt;
  logic [7:0] icnt_r, icnt_nxt;
  logic [3:0] nbits;
  logic [7:0] imax;
  logic       bitv, cnt_en, fall;

  always_comb begin
    st_nxt     = st_r;
    ph_nxt     = ph_r;
    idx_nxt    = idx_r;
    frm_nxt    = frm_r;
    hist_nxt   = hist_r;
    smp_nxt    = smp_r;
    sh_nxt     = sh_r;
    last_nxt   = last_r;
    nz_nxt     = nz_r;
    rs_nxt     = rs_r;
    icnt_nxt   = icnt_r;
    frame_done = 1'b0;
    wake_addr  = 1'b0;
    idle_evt   = 1'b0;
    nbits      = ctrl_r.char_len_nine ? `URX_BITS_9 : `URX_BITS_8;   // R02
    imax       = ctrl_r.char_len_nine ? `URX_IDLE_9 : `URX_IDLE_8;   // R15
    bitv       = maj3({smp_r[1:0], rx_bit});
    fall       = hist_r[0] && !rx_bit;
    // origin zero counts from the end of the start bit, one only after stop
    cnt_en     = (st_r == urx_pkg::URX_S_IDLE) ||
                 (!ctrl_r.idle_count_origin && st_r != urx_pkg::URX_S_START);   // R14
    frame_data = ctrl_r.char_len_nine ? sh_r : {1'b0, sh_r[8:1]};
    stop_smp   = smp_r;
    data_noise = nz_r;
    if (!ctrl_r.receiver_enable) begin
      st_nxt   = urx_pkg::URX_S_IDLE;
      hist_nxt = 3'h0;
      icnt_nxt = 8'h00;
    end else if (rt_tick) begin
      hist_nxt = {hist_r[1:0], rx_bit};
      frm_nxt  = frm_r + 8'h01;
      if (ph_r == `URX_OVS) begin
        ph_nxt = `URX_PH_FIRST;
      end else begin
        ph_nxt = ph_r + 5'h01;
      end
      if (!rx_bit) begin
        icnt_nxt = 8'h00;
      end else if (cnt_en && icnt_r != imax) begin
        icnt_nxt = icnt_r + 8'h01;
        idle_evt = (icnt_r == imax - 8'h01);                           // R15
      end
      case (st_r)
        urx_pkg::URX_S_IDLE: begin
          // falling edge after three ones is a candidate start, this tick is RT1
          if (hist_r == 3'h7 && !rx_bit) begin
            st_nxt = urx_pkg::URX_S_START;
            ph_nxt = `URX_PH_RT2;
            frm_nxt = 8'h01;
            idx_nxt = 4'h0;
            nz_nxt = 1'b0;
            rs_nxt = 1'b0;
          end
        end
        urx_pkg::URX_S_START: begin
          if (ph_r == `URX_PH_RT3 || ph_r == `URX_PH_RT5) begin
            smp_nxt = {smp_r[1:0], rx_bit};
          end
          if (ph_r == `URX_PH_RT7) begin
            if (bitv) begin
              st_nxt = urx_pkg::URX_S_IDLE;
            end else begin
              nz_nxt = mixed3({smp_r[1:0], rx_bit});
            end
          end
          if (ph_r == `URX_OVS) begin
            st_nxt = urx_pkg::URX_S_DATA;
            idx_nxt = 4'h1;
            last_nxt = 1'b0;
          end
        end
        urx_pkg::URX_S_DATA: begin
          if (ph_r == `URX_PH_RT8 || ph_r == `URX_PH_RT9) begin
            smp_nxt = {smp_r[1:0], rx_bit};
          end
          if (ph_r == `URX_PH_RT10) begin
            sh_nxt = {bitv, sh_r[8:1]};
            last_nxt = bitv;
            nz_nxt = nz_r | mixed3({smp_r[1:0], rx_bit});
            // msb one in standby with address wake: leave before the stop bit
            wake_addr = ctrl_r.standby_request && ctrl_r.wake_select &&
                        idx_r == nbits && bitv;                          // R16 R17
          end
          if (fall && last_r && ph_r >= `URX_PH_RT11) begin
            // fast sender: next bit already started, realign to its edge
            ph_nxt = `URX_PH_RT2;                                        // R05
            rs_nxt = 1'b1;
            idx_nxt = idx_r + 4'h1;
            last_nxt = 1'b0;
            if (idx_r == nbits) begin
              st_nxt = urx_pkg::URX_S_STOP;
            end
          end else if (fall && last_r && idx_r > 4'h1 && ph_r <= `URX_PH_RT4) begin
            ph_nxt = `URX_PH_RT2;                                        // R05
            rs_nxt = 1'b1;
          end else if (ph_r == `URX_OVS) begin
            idx_nxt = idx_r + 4'h1;
            if (idx_r == nbits) begin
              st_nxt = urx_pkg::URX_S_STOP;
            end
          end
        end
        urx_pkg::URX_S_STOP: begin
          if (ph_r == `URX_PH_RT8 || ph_r == `URX_PH_RT9 || ph_r == `URX_PH_RT10) begin
            smp_nxt = {smp_r[1:0], rx_bit};                              // R06 R07
          end
          if (ph_r == `URX_PH_RT11) begin
            frame_done = 1'b1;                                           // R08
            st_nxt = urx_pkg::URX_S_IDLE;
            if (ctrl_r.idle_count_origin) begin
              icnt_nxt = 8'h00;                                          // R14
            end
          end
        end
        default: begin
          st_nxt = urx_pkg::URX_S_IDLE;
        end
      endcase
    end
    // idle level also wakes a receiver that was put to sleep on an idle line
    wake_idle = ctrl_r.standby_request && !ctrl_r.wake_select &&
                icnt_r == imax;                                          // R11 R12 R18
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= urx_pkg::URX_S_IDLE;
      ph_r   <= `URX_PH_FIRST;
      idx_r  <= 4'h0;
      frm_r  <= 8'h00;
      hist_r <= 3'h0;
      smp_r  <= 3'h0;
      sh_r   <= 9'h000;
      last_r <= 1'b0;
      nz_r   <= 1'b0;
      rs_r   <= 1'b0;
      icnt_r <= 8'h00;
    end else begin
      st_r   <= st_nxt;
      ph_r   <= ph_nxt;
      idx_r  <= idx_nxt;
      frm_r  <= frm_nxt;
      hist_r <= hist_nxt;
      smp_r  <= smp_nxt;
      sh_r   <= sh_nxt;
      last_r <= last_nxt;
      nz_r   <= nz_nxt;
      rs_r   <= rs_nxt;
      icnt_r <= icnt_nxt;
    end
  end

  // ****************************************
  // apb slave and registers
  // ****************************************
  logic acc, wr_en;

  always_comb begin
    acc          = psel && penable && !pready;
    wr_en        = psel && penable && pready && pwrite && !pslverr;
    ctrl_nxt     = ctrl_r;
    stat_nxt     = stat_r;
    div_nxt      = div_r;
    data_nxt     = data_r;
    idle_arm_nxt = idle_arm_r;
    pready_nxt   = acc;
    pslverr_nxt  = acc && !mapped(paddr);
    prdata_nxt   = prdata;
    if (wake_idle || wake_addr) begin
      ctrl_nxt.standby_request = 1'b0;                                   // R12 R16
    end
    if (wr_en) begin
      case (paddr[7:0])
        `URX_OFF_CTRL:   ctrl_nxt = pwdata[10:0];
        `URX_OFF_BAUD:   div_nxt  = pwdata[DIV_W-1:0];
        // write one to clear; hardware sets below win
        `URX_OFF_STATUS: stat_nxt = stat_r & ~pwdata[4:0];
        default:         ;
      endcase
    end
    if (frame_done) begin
      data_nxt = frame_data;                                             // R10
      if (!ctrl_r.standby_request) begin
        if (stat_r.rx_buffer_full_flag) begin
          stat_nxt.overrun = 1'b1;
          data_nxt = data_r;
        end else begin
          stat_nxt.rx_buffer_full_flag = 1'b1;                           // R17
          idle_arm_nxt = 1'b1;
        end
        stat_nxt.framing_err = !maj3(stop_smp) | stat_nxt.framing_err;   // R04
        stat_nxt.noise_err   = mixed3(stop_smp) | data_noise | stat_nxt.noise_err;   // R03
      end
    end
    if (idle_evt && idle_arm_r && !ctrl_r.standby_request) begin
      stat_nxt.idle_flag = 1'b1;                                         // R13
      idle_arm_nxt = 1'b0;
    end
    if (acc) begin
      case (paddr[7:0])
        `URX_OFF_CTRL:   prdata_nxt = {21'h0, ctrl_r};
        `URX_OFF_BAUD:   prdata_nxt = {{(32-DIV_W){1'b0}}, div_r};
        `URX_OFF_STATUS: prdata_nxt = {26'h0, st_r != urx_pkg::URX_S_IDLE, stat_r};
        `URX_OFF_DATA:   prdata_nxt = {23'h0, data_r};
        default:         prdata_nxt = 32'h0;
      endcase
    end
    txd_out_nxt = tx_serial;
    // single-wire input direction leaves the shared pin to the remote node
    txd_oe_nxt  = ctrl_r.transmitter_enable &&
                  !(ctrl_r.loop_enable && ctrl_r.receive_source_select &&
                    !ctrl_r.shared_pin_direction);                       // R21 R25
    req_nxt     = !ctrl_nxt.standby_request &&
                  (stat_nxt != urx_pkg::urx_stat_t'(`URX_STAT_RST));     // R09
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r      <= `URX_CTRL_RST;
      stat_r      <= `URX_STAT_RST;
      div_r       <= `URX_BAUD_RST;
      data_r      <= 9'h000;
      idle_arm_r  <= 1'b0;
      prdata      <= 32'h0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      txd_pin_out <= 1'b1;
      txd_pin_oe  <= 1'b0;
      rx_request  <= 1'b0;
    end else begin
      ctrl_r      <= ctrl_nxt;
      stat_r      <= stat_nxt;
      div_r       <= div_nxt;
      data_r      <= data_nxt;
      idle_arm_r  <= idle_arm_nxt;
      prdata      <= prdata_nxt;
      pready      <= pready_nxt;
      pslverr     <= pslverr_nxt;
      txd_pin_out <= txd_out_nxt;
      txd_pin_oe  <= txd_oe_nxt;
      rx_request  <= req_nxt;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_stop_beg8;
    @(posedge pclk) disable iff (!presetn)
    (rt_tick && st_r == urx_pkg::URX_S_STOP && ph_r == `URX_PH_RT8 && !rs_r &&
     !ctrl_r.char_len_nine) |-> frm_r == `URX_STOP_BEG_8;
  endproperty
  a_stop_beg8: assert property (p_stop_beg8) else $error("stop start not at 151"); // R06

  property p_stop_beg9;
    @(posedge pclk) disable iff (!presetn)
    (rt_tick && st_r == urx_pkg::URX_S_STOP && ph_r == `URX_PH_RT8 && !rs_r &&
     ctrl_r.char_len_nine) |-> frm_r == `URX_STOP_BEG_9;
  endproperty
  a_stop_beg9: assert property (p_stop_beg9) else $error("stop start not at 167"); // R07

  property p_stop_end;
    @(posedge pclk) disable iff (!presetn)
    (frame_done && !rs_r) |->
      frm_r == (ctrl_r.char_len_nine ? `URX_STOP_END_9 : `URX_STOP_END_8);
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("stop end count wrong"); // R08

  property p_noise;
    @(posedge pclk) disable iff (!presetn)
    (frame_done && !ctrl_r.standby_request && mixed3(smp_r)) |=> stat_r.noise_err;
  endproperty
  a_noise: assert property (p_noise) else $error("noise not flagged"); // R03

  property p_framing;
    @(posedge pclk) disable iff (!presetn)
    (frame_done && !ctrl_r.standby_request && !maj3(smp_r)) |=> stat_r.framing_err;
  endproperty
  a_framing: assert property (p_framing) else $error("framing not flagged"); // R04

  property p_standby_full;
    @(posedge pclk) disable iff (!presetn)
    (frame_done && ctrl_r.standby_request && !stat_r.rx_buffer_full_flag) |=>
      !stat_r.rx_buffer_full_flag && data_r == $past(frame_data);
  endproperty
  a_standby_full: assert property (p_standby_full) else $error("standby frame bad"); // R10

  property p_idle_wake;
    @(posedge pclk) disable iff (!presetn)
    (wake_idle && !wr_en) |=> !ctrl_r.standby_request && !$rose(stat_r.idle_flag);
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake wrong"); // R12 R13

  property p_addr_wake;
    @(posedge pclk) disable iff (!presetn)
    (wake_addr && !wr_en) |=> !ctrl_r.standby_request ##[0:200] frame_done;
  endproperty
  a_addr_wake: assert property (p_addr_wake) else $error("address wake wrong"); // R16 R17

  property p_request;
    @(posedge pclk) disable iff (!presetn)
    ctrl_r.standby_request [*2] |-> !rx_request;
  endproperty
  a_request: assert property (p_request) else $error("request in standby"); // R09

  property p_pin_oe;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_r.loop_enable && ctrl_r.receive_source_select &&
     !ctrl_r.shared_pin_direction) |=> !txd_pin_oe;
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("shared pin driven"); // R21 R25

  property p_loop_src;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_r.loop_enable && !ctrl_r.receive_source_select) |->
      rx_bit == (tx_serial ^ ctrl_r.receive_polarity);
  endproperty
  a_loop_src: assert property (p_loop_src) else $error("loop path wrong"); // R23 R24

  c_frame:   cover property (@(posedge pclk) disable iff (!presetn) frame_done);
  c_resync:  cover property (@(posedge pclk) disable iff (!presetn) frame_done && rs_r);
  c_wake_i:  cover property (@(posedge pclk) disable iff (!presetn) wake_idle);
  c_wake_a:  cover property (@(posedge pclk) disable iff (!presetn) wake_addr);

endmodule

// ==== verif/urx_remote_node.sv ====
`timescale 1ns/10ps
// ********************
// remote serial sender
// ********************
module urx_remote_node (
  // clock
  input  wire logic pclk,
  // serial line, driven high between frames like a real sender
  output logic      line
);
  initial line = 1'b1;
  // bit length in pclk cycles lets a frame run slow or fast
  task automatic send(input logic [8:0] d, input logic nine, input int bl,
                      input logic stp);
    logic [10:0] f;
    f = nine ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      line <= f[i];
      repeat (bl) @(posedge pclk);
    end
    line <= 1'b1;
  endtask
endmodule

// ==== verif/tb_uart_rx_wakeup_loop_routing.sv ====
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin n_errors++; \
  $display("FAIL %s expected %h seen %h", nm, ex, gt); end end
module tb_uart_rx_wakeup_loop_routing;
  typedef struct packed {
    logic [8:0] d;
    logic       nine;
    logic [4:0] bl;
    logic       stp;
    logic [4:0] st;
  } urx_row_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0]  route = 2'h0;
  logic        inv = 1'b0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic        err;
  logic        pready, pslverr, txd_pin_out, txd_pin_oe, rx_request, line;
  int          n_errors = 0;
  int          n_compared = 0;
  int          lat;
  int          e;
  urx_row_t    r;
  // zero data with a slow sender: no resync, stop samples straddle the edge
  urx_row_t    rows [7] = '{'{9'h055, 1'b0, 5'h10, 1'b1, 5'h01},
                            '{9'h000, 1'b0, 5'h11, 1'b1, 5'h0d},
                            '{9'h1f0, 1'b1, 5'h10, 1'b1, 5'h01},
                            '{9'h1a5, 1'b1, 5'h10, 1'b1, 5'h01},
                            '{9'h055, 1'b0, 5'h11, 1'b1, 5'h01},
                            '{9'h055, 1'b0, 5'h0f, 1'b1, 5'h01},
                            '{9'h0f0, 1'b0, 5'h10, 1'b0, 5'h09}};
  // rxd held low off route 0: a leak past isolation shows as a break
  wire logic rxd_pin = (route == 2'h0) ? line : 1'b0;
  wire logic tx_serial = (route == 2'h1) ? (line ^ inv) : 1'b1;
  wire logic txd_pin_in = txd_pin_oe ? txd_pin_out : ((route == 2'h2) ? (line ^ inv) : 1'b1);

  always #5 pclk = ~pclk;

  urx_rx #(.ADDR_W(8), .DIV_W(16)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_pin(rxd_pin), .txd_pin_in(txd_pin_in), .txd_pin_out(txd_pin_out),
    .txd_pin_oe(txd_pin_oe), .tx_serial(tx_serial), .rx_request(rx_request));
  urx_remote_node i_node (.pclk(pclk), .line(line));

  // ********************
  // bus and frame tasks
  // ********************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) n_errors++;
  endtask

  task automatic rx_check(input logic [8:0] d, input logic [4:0] st, input int bl = 16);
    apb(1'b1, 8'h08, 32'h1f);
    i_node.send(d, 1'b0, bl, 1'b1);
    repeat (30) @(posedge pclk);
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("data", {23'h0, d}, q)
    apb(1'b0, 8'h08, 32'h0);
    `CHK("status", {27'h0, st}, q)
  endtask

  task automatic conclude();
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ********************
  // sequence
  // ********************
  initial begin
    repeat (20) @(posedge pclk);
    `CHK("oe_reset", 1'b0, txd_pin_oe)
    presetn <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'b1, 8'h00, {29'h0, r.nine, 2'b11});
      apb(1'b1, 8'h08, 32'h1f);
      repeat (3) @(posedge pclk);
      lat = 0;
      fork
        i_node.send(r.d, r.nine, int'(r.bl), r.stp);
        while (rx_request !== 1'b1 && lat < 400) begin
          @(posedge pclk);
          lat++;
        end
      join
      e = r.nine ? 170 : 154;
      if (r.bl == 5'h10) `CHK("latency", 1'b1, lat >= e && lat <= e + 8)
      apb(1'b0, 8'h0c, 32'h0);
      `CHK("data", {23'h0, r.d}, q)
      repeat (400) @(posedge pclk);
      apb(1'b0, 8'h08, 32'h0);
      `CHK("status", {27'h0, r.st | 5'h02}, q)
      `CHK("request", 1'b1, rx_request)
    end
    // address-mark standby: plain frame loaded silently, address frame wakes
    apb(1'b1, 8'h00, 32'h40b);
    rx_check(9'h012, 5'h00);
    `CHK("req_standby", 1'b0, rx_request)
    rx_check(9'h092, 5'h01);
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl_woke", 32'h00b, q)
    // idle-line standby armed mid-frame so the line was not idle before
    apb(1'b1, 8'h00, 32'h003);
    apb(1'b1, 8'h08, 32'h1f);
    fork
      i_node.send(9'h033, 1'b0, 16, 1'b1);
      apb(1'b1, 8'h00, 32'h403);
    join
    repeat (400) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl_idle_wake", 32'h003, q)
    apb(1'b0, 8'h08, 32'h0);
    `CHK("status_idle_wake", 32'h0, q)
    // standby set on a line that is already idle ends at once
    apb(1'b1, 8'h00, 32'h403);
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl_idle_at_once", 32'h003, q)
    // idle counted from the stop bit: an all-ones frame is not idle yet
    apb(1'b1, 8'h00, 32'h013);
    rx_check(9'h0ff, 5'h01);
    repeat (200) @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    `CHK("status_idle_late", 32'h03, q)
    // slower tick: two clocks per oversample
    apb(1'b1, 8'h04, 32'h2);
    rx_check(9'h0a6, 5'h01, 32);
    apb(1'b1, 8'h04, 32'h1);
    // loop with matching polarities, stream inverted by the sender side
    apb(1'b1, 8'h00, 32'h323);
    route <= 2'h1;
    inv <= 1'b1;
    rx_check(9'h03c, 5'h01);
    // single wire, shared pin as input, inverted line
    apb(1'b1, 8'h00, 32'h163);
    route <= 2'h2;
    repeat (40) @(posedge pclk);
    `CHK("oe_input", 1'b0, txd_pin_oe)
    rx_check(9'h05a, 5'h01);
    apb(1'b1, 8'h00, 32'h1e3);
    repeat (3) @(posedge pclk);
    `CHK("oe_output", 1'b1, txd_pin_oe)
    `CHK("pin_out", 1'b1, txd_pin_out)
    conclude();
  end

  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    conclude();
  end
endmodule
